// File: src/pldm_pkg.sv
// pldm_pkg: constants, types and register map of the dual-register macrocell array
// assumes: one 200 MHz system clock; software reaches the block over APB

package pldm_pkg;

   // ----------------------------------------------------------------
   // array geometry
   // ----------------------------------------------------------------
   localparam int PLDM_NUM_IN = 12;
   localparam int PLDM_NUM_IO = 10;
   localparam int PLDM_NUM_REG = 20;
   localparam int PLDM_ARR_W = PLDM_NUM_IN + PLDM_NUM_IO + PLDM_NUM_REG;
   localparam int PLDM_PT_PER_SUM = 2;
   localparam int PLDM_HI_W = PLDM_ARR_W - 32;

   // ----------------------------------------------------------------
   // term table layout: data, reset, clock, output enable, preset
   // ----------------------------------------------------------------
   localparam int PLDM_T_DATA_BASE = 0;
   localparam int PLDM_T_RST_BASE = PLDM_NUM_REG * PLDM_PT_PER_SUM;
   localparam int PLDM_T_CLK_BASE = PLDM_T_RST_BASE + PLDM_NUM_REG;
   localparam int PLDM_T_OE_BASE = PLDM_T_CLK_BASE + PLDM_NUM_REG;
   localparam int PLDM_T_PRESET = PLDM_T_OE_BASE + PLDM_NUM_IO;
   localparam int PLDM_NUM_TERM = PLDM_T_PRESET + 1;
   localparam int PLDM_TIDX_W = 7;

   // ----------------------------------------------------------------
   // APB register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] PLDM_ADDR_CTRL = 8'h00;
   localparam logic [7:0] PLDM_ADDR_TYPE = 8'h04;
   localparam logic [7:0] PLDM_ADDR_CSEL = 8'h08;
   localparam logic [7:0] PLDM_ADDR_TIDX = 8'h0c;
   localparam logic [7:0] PLDM_ADDR_MASK_LO = 8'h10;
   localparam logic [7:0] PLDM_ADDR_MASK_HI = 8'h14;
   localparam logic [7:0] PLDM_ADDR_VAL_LO = 8'h18;
   localparam logic [7:0] PLDM_ADDR_VAL_HI = 8'h1c;
   localparam logic [7:0] PLDM_ADDR_STATE = 8'h20;
   localparam logic [7:0] PLDM_ADDR_PINS = 8'h24;

   // control fields and reset values
   localparam int PLDM_CTRL_SEC_BIT = 0;
   localparam int PLDM_CTRL_RUN_BIT = 1;
   localparam logic [1:0] PLDM_CTRL_RST = 2'h0;
   localparam logic [PLDM_NUM_REG-1:0] PLDM_TYPE_RST = 20'h00000;
   localparam logic [PLDM_NUM_REG-1:0] PLDM_CSEL_RST = 20'h00000;
   localparam logic [PLDM_NUM_REG-1:0] PLDM_Q_RST = 20'h00000;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [PLDM_ARR_W-1:0] mask;
      logic [PLDM_ARR_W-1:0] val;
   } pldm_term_t;

   typedef struct packed {
      logic [PLDM_NUM_IN-1:0] in_pin;
      logic [PLDM_NUM_IO-1:0] io_pin;
      logic [PLDM_NUM_REG-1:0] fb;
   } pldm_array_t;

endpackage

// File: src/pldm_sync.sv
// pldm_sync: two-flop synchroniser for a vector of pin levels
// assumes: inputs are asynchronous levels, not pulses

`timescale 1ns/1ps

module pldm_sync #(
   parameter int WIDTH = 1
) (
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic [WIDTH-1:0] ASYNC_IN,
   output logic [WIDTH-1:0] SYNC_OUT
);

   logic [WIDTH-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         meta <= '0;
         SYNC_OUT <= '0;
      end else begin
         meta <= ASYNC_IN;
         SYNC_OUT <= meta;
      end
   end

endmodule

// File: src/pldm_pterm.sv
// pldm_pterm: one programmable product term over the array inputs
// assumes: an all-zero mask means an unused term, which stays false

`timescale 1ns/1ps

module pldm_pterm
   import pldm_pkg::*;
(
   input wire pldm_array_t ARR,
   input wire pldm_term_t TERM,
   output logic HIT
);

   // every cared-for input must match its programmed level
   assign HIT = (|TERM.mask) && (((ARR ^ TERM.val) & TERM.mask) == '0);

endmodule

// File: src/pldm_top.sv
// pldm_top: twenty-register programmable macrocell array with APB set-up port
// assumes: pins are asynchronous to CLK_SYS; the board keeps preset timing
//
// Summary of operation
// - each flip-flop is set on its own to act as a D or a T register.
// - each flip-flop is clocked either by its own clock term or by the clock pin.
// - there are two flip-flops per output cell, twenty in all.
// - each register has its own data sum, its own reset term and its own clock term.
// - each I/O pin has its own input path into the array, apart from feedback.
// - all twenty registers, buried ones too, feed their value back into the array.
// - each I/O pin has its own output-enable product term.
// - one synchronous preset term sets all registers on their clock edge.
// - each flip-flop has its own asynchronous reset line.
// - a high reset term clears the whole flip-flop at once, with no clock edge.
// - once the security fuse is set, the D/T, clock-select and term mask/value fields read back as ones; control and term index do not.
//
// Local design decisions: register access over APB and the address map.

`timescale 1ns/1ps

module pldm_top
   import pldm_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic CLK_PIN,
   input wire logic [PLDM_NUM_IN-1:0] IN_PIN,
   input wire logic [PLDM_NUM_IO-1:0] IO_IN,
   output logic [PLDM_NUM_IO-1:0] IO_OUT,
   output logic [PLDM_NUM_IO-1:0] IO_OE
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [1:0] ctrl;
   logic secure;
   logic run;
   logic [PLDM_NUM_REG-1:0] t_type;
   logic [PLDM_NUM_REG-1:0] pin_clk;
   logic [PLDM_TIDX_W-1:0] term_idx;
   pldm_term_t term_mem [PLDM_NUM_TERM];
   logic [PLDM_NUM_TERM-1:0] hit;
   logic [PLDM_NUM_IN-1:0] in_s;
   logic [PLDM_NUM_IO-1:0] io_s;
   logic clk_pin_s;
   logic clk_pin_prev;
   logic pin_edge;
   logic [PLDM_NUM_REG-1:0] q;
   pldm_array_t arr;
   logic preset;
   logic idx_ok;
   logic addr_ok;
   logic setup_ph;
   logic wr_en;
   logic [31:0] next_rdata;
   pldm_term_t cur_term;

   assign secure = ctrl[PLDM_CTRL_SEC_BIT];
   assign run = ctrl[PLDM_CTRL_RUN_BIT];

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------

   // no wait states; errors only on unmapped offsets
   // writes to the read-only offsets are taken and ignored
   assign PREADY = 1'b1;
   assign setup_ph = PSEL && !PENABLE;
   assign wr_en = PSEL && PENABLE && PWRITE && addr_ok;
   assign idx_ok = (term_idx < PLDM_TIDX_W'(PLDM_NUM_TERM));

   // offset decode
   always_comb begin
      case (PADDR)
         PLDM_ADDR_CTRL,
         PLDM_ADDR_TYPE,
         PLDM_ADDR_CSEL,
         PLDM_ADDR_TIDX,
         PLDM_ADDR_MASK_LO,
         PLDM_ADDR_MASK_HI,
         PLDM_ADDR_VAL_LO,
         PLDM_ADDR_VAL_HI,
         PLDM_ADDR_STATE,
         PLDM_ADDR_PINS: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   assign PSLVERR = PSEL && PENABLE && !addr_ok;

   // selected term for read-back, zero when the index is out of range
   assign cur_term = idx_ok ? term_mem[term_idx] : '0;

   // read data mux; hidden fields show as ones once secured
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (PADDR)
         PLDM_ADDR_CTRL: begin
            next_rdata[1:0] = ctrl;
         end
         PLDM_ADDR_TYPE: begin
            next_rdata[PLDM_NUM_REG-1:0] = secure ? '1 : t_type;
         end
         PLDM_ADDR_CSEL: begin
            next_rdata[PLDM_NUM_REG-1:0] = secure ? '1 : pin_clk;
         end
         PLDM_ADDR_TIDX: begin
            next_rdata[PLDM_TIDX_W-1:0] = term_idx;
         end
         PLDM_ADDR_MASK_LO: begin
            next_rdata = secure ? '1 : cur_term.mask[31:0];
         end
         PLDM_ADDR_MASK_HI: begin
            next_rdata[PLDM_HI_W-1:0] = secure ? '1 : cur_term.mask[PLDM_ARR_W-1:32];
         end
         PLDM_ADDR_VAL_LO: begin
            next_rdata = secure ? '1 : cur_term.val[31:0];
         end
         PLDM_ADDR_VAL_HI: begin
            next_rdata[PLDM_HI_W-1:0] = secure ? '1 : cur_term.val[PLDM_ARR_W-1:32];
         end
         PLDM_ADDR_STATE: begin
            next_rdata[PLDM_NUM_REG-1:0] = q;
         end
         PLDM_ADDR_PINS: begin
            next_rdata[PLDM_NUM_IN+PLDM_NUM_IO-1:0] = {in_s, io_s};
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   // read data captured in the setup cycle, stable through the access
   // a read shows state as of the setup edge, one cycle before the access
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         PRDATA <= 32'h0000_0000;
      end else if (setup_ph) begin
         PRDATA <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------

   // control: security bit is sticky until reset, run bit is free
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         ctrl <= PLDM_CTRL_RST;
      end else if (wr_en && PADDR == PLDM_ADDR_CTRL) begin
         ctrl[PLDM_CTRL_SEC_BIT] <= secure | PWDATA[PLDM_CTRL_SEC_BIT];
         ctrl[PLDM_CTRL_RUN_BIT] <= PWDATA[PLDM_CTRL_RUN_BIT];
      end
   end

   // per-register D/T choice
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         t_type <= PLDM_TYPE_RST;
      end else if (wr_en && PADDR == PLDM_ADDR_TYPE) begin
         t_type <= PWDATA[PLDM_NUM_REG-1:0];
      end
   end

   // per-register clock source choice
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         pin_clk <= PLDM_CSEL_RST;
      end else if (wr_en && PADDR == PLDM_ADDR_CSEL) begin
         pin_clk <= PWDATA[PLDM_NUM_REG-1:0];
      end
   end

   // term table index
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         term_idx <= '0;
      end else if (wr_en && PADDR == PLDM_ADDR_TIDX) begin
         term_idx <= PWDATA[PLDM_TIDX_W-1:0];
      end
   end

   // term table: all terms cleared, so every term starts false
   // a half-written term may match for a cycle; program with run low
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         for (int i = 0; i < PLDM_NUM_TERM; i++) begin
            term_mem[i] <= '0;
         end
      end else if (wr_en && idx_ok) begin
         case (PADDR)
            PLDM_ADDR_MASK_LO: begin
               term_mem[term_idx].mask[31:0] <= PWDATA;
            end
            PLDM_ADDR_MASK_HI: begin
               term_mem[term_idx].mask[PLDM_ARR_W-1:32] <= PWDATA[PLDM_HI_W-1:0];
            end
            PLDM_ADDR_VAL_LO: begin
               term_mem[term_idx].val[31:0] <= PWDATA;
            end
            PLDM_ADDR_VAL_HI: begin
               term_mem[term_idx].val[PLDM_ARR_W-1:32] <= PWDATA[PLDM_HI_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pin inputs
   // ----------------------------------------------------------------

   // dedicated inputs and I/O input paths, apart from feedback
   pldm_sync #(.WIDTH(PLDM_NUM_IN + PLDM_NUM_IO + 1)) u_pin_sync (
      .CLK_SYS(CLK_SYS),
      .RST_B(RST_B),
      .ASYNC_IN({IN_PIN, IO_IN, CLK_PIN}),
      .SYNC_OUT({in_s, io_s, clk_pin_s})
   );

   // rising edge of the clock pin
   // a pin edge acts three system clocks after the pin rises
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         clk_pin_prev <= 1'b0;
      end else begin
         clk_pin_prev <= clk_pin_s;
      end
   end

   assign pin_edge = clk_pin_s && !clk_pin_prev;

   // ----------------------------------------------------------------
   // logic array
   // ----------------------------------------------------------------

   // array inputs: pins, I/O paths and every register's feedback
   assign arr.in_pin = in_s;
   assign arr.io_pin = io_s;
   assign arr.fb = q;

   // one evaluator per term of the table
   for (genvar t = 0; t < PLDM_NUM_TERM; t++) begin : g_term
      pldm_pterm u_pterm (
         .ARR(arr),
         .TERM(term_mem[t]),
         .HIT(hit[t])
      );
   end

   // single preset term shared by all registers
   // reset terms still win over it, and it wins over data
   assign preset = hit[PLDM_T_PRESET];

   // ----------------------------------------------------------------
   // macrocell registers: two per output cell
   // ----------------------------------------------------------------
   for (genvar r = 0; r < PLDM_NUM_REG; r++) begin : g_reg
      logic sum;
      logic rst_t;
      logic clk_t;
      logic clk_t_prev;
      logic clk_edge;
      logic q_bit;

      // private sum, reset and clock terms
      assign sum = |hit[PLDM_T_DATA_BASE + r * PLDM_PT_PER_SUM +: PLDM_PT_PER_SUM];
      assign rst_t = hit[PLDM_T_RST_BASE + r];
      assign clk_t = hit[PLDM_T_CLK_BASE + r];

      // history of the clock term; it keeps tracking through a reset term
      // so that releasing the reset gives no false edge
      always_ff @(posedge CLK_SYS) begin
         if (!RST_B) begin
            clk_t_prev <= 1'b0;
         end else if (rst_t) begin
            clk_t_prev <= clk_t;
         end else begin
            clk_t_prev <= clk_t;
         end
      end

      // edge from the chosen source
      assign clk_edge = pin_clk[r] ? pin_edge : (clk_t && !clk_t_prev);

      // reset needs no edge; preset and data act on the edge
      always_ff @(posedge CLK_SYS) begin
         if (!RST_B) begin
            q_bit <= PLDM_Q_RST[r];
         end else if (rst_t) begin
            q_bit <= 1'b0;
         end else if (run && clk_edge) begin
            if (preset) begin
               q_bit <= 1'b1;
            end else if (t_type[r]) begin
               q_bit <= q_bit ^ sum;
            end else begin
               q_bit <= sum;
            end
         end
      end

      assign q[r] = q_bit;
   end

   // ----------------------------------------------------------------
   // I/O pin drivers
   // ----------------------------------------------------------------

   // first register of each cell drives the pin, the second is buried
   // the pin lags its register by one system clock
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         IO_OUT <= '0;
      end else begin
         IO_OUT <= q[PLDM_NUM_IO-1:0];
      end
   end

   // each pin has its own enable term; stopped array floats all pins
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         IO_OE <= '0;
      end else begin
         IO_OE <= run ? hit[PLDM_T_OE_BASE +: PLDM_NUM_IO] : '0;
      end
   end

endmodule

// File: tb/pldm_top_sva.sv
// pldm_top_sva: port-level checks of the macrocell array
// assumes: bound into pldm_top, one clock domain
`timescale 1ns/1ps
module pldm_top_sva
   import pldm_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [PLDM_NUM_IN-1:0] IN_PIN,
   input wire logic [PLDM_NUM_IO-1:0] IO_IN,
   input wire logic [PLDM_NUM_IO-1:0] IO_OUT,
   input wire logic [PLDM_NUM_IO-1:0] IO_OE
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_B);
   // ----------------------------------------
   // shadow of control bits, pin stability
   // ----------------------------------------
   logic sec;
   logic run;
   logic [2:0] still;
   logic [21:0] pins_q;
   logic acc;
   logic rd;
   assign acc = PSEL && PENABLE;
   assign rd = acc && !PWRITE;
   // control bits as software wrote them
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         sec <= 1'b0;
         run <= 1'b0;
      end else if (acc && PWRITE && PADDR == PLDM_ADDR_CTRL) begin
         sec <= sec | PWDATA[0];
         run <= PWDATA[1];
      end
   end
   // count of cycles with unchanged pins
   always_ff @(posedge CLK_SYS) begin
      pins_q <= {IN_PIN, IO_IN};
      if (!RST_B || pins_q != {IN_PIN, IO_IN}) begin
         still <= 3'h0;
      end else if (still != 3'h7) begin
         still <= still + 3'h1;
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_answer;
      acc && PADDR[1:0] == 2'h0 |-> PREADY && PSLVERR == (PADDR > PLDM_ADDR_PINS);
   endproperty
   a_answer: assert property (p_answer) else $error("bad apb answer");
   property p_err_data;
      rd && PSLVERR |-> PRDATA == 32'h0;
   endproperty
   a_err_data: assert property (p_err_data) else $error("refused read not zero");
   property p_sec_type;
      sec && rd && (PADDR == PLDM_ADDR_TYPE || PADDR == PLDM_ADDR_CSEL)
         |-> PRDATA == 32'h000fffff;
   endproperty
   a_sec_type: assert property (p_sec_type) else $error("secured select");
   property p_sec_lo;
      sec && rd && (PADDR == PLDM_ADDR_MASK_LO || PADDR == PLDM_ADDR_VAL_LO)
         |-> PRDATA == 32'hffffffff;
   endproperty
   a_sec_lo: assert property (p_sec_lo) else $error("secured low word");
   property p_sec_hi;
      sec && rd && (PADDR == PLDM_ADDR_MASK_HI || PADDR == PLDM_ADDR_VAL_HI)
         |-> PRDATA == 32'h000003ff;
   endproperty
   a_sec_hi: assert property (p_sec_hi) else $error("secured high word");
   property p_pins;
      rd && PADDR == PLDM_ADDR_PINS && still >= 3'h5 |-> PRDATA == {10'h0, pins_q};
   endproperty
   a_pins: assert property (p_pins) else $error("pin input path");
   property p_oe_off;
      !run [*3] |-> IO_OE == 10'h000;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("enable while stopped");
   property p_frozen;
      !run [*3] |=> (IO_OUT & ~$past(IO_OUT)) == 10'h000;
   endproperty
   a_frozen: assert property (p_frozen) else $error("set while stopped");
   property p_rst_out;
      $rose(RST_B) |-> IO_OUT == 10'h000 && IO_OE == 10'h000 && PRDATA == 32'h0;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("outputs after reset");
   c_sec_read: cover property (sec && rd);
   c_err: cover property (acc && PSLVERR);
   c_oe: cover property (|IO_OE);
endmodule
bind pldm_top pldm_top_sva u_sva (.CLK_SYS, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR,
   .PWDATA, .PRDATA, .PREADY, .PSLVERR, .IN_PIN, .IO_IN, .IO_OUT, .IO_OE);

// File: tb/pldm_board.sv
// pldm_board: board logic driving the pins and pin clock
// assumes: tasks are called just after a rising CLK_SYS edge
`timescale 1ns/1ps
module pldm_board
   import pldm_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic [PLDM_NUM_IO-1:0] IO_OUT,
   input wire logic [PLDM_NUM_IO-1:0] IO_OE,
   output logic CLK_PIN,
   output logic [PLDM_NUM_IN-1:0] IN_PIN,
   output logic [PLDM_NUM_IO-1:0] IO_IN
);
   logic [PLDM_NUM_IO-1:0] drv;
   // quiet pins, pin clock stands low between pulses
   initial begin
      CLK_PIN = 1'b0;
      IN_PIN = 12'h000;
      drv = 10'h000;
   end
   // wire level: the cell wins where it drives
   assign IO_IN = (IO_OE & IO_OUT) | (~IO_OE & drv);
   // new levels, then time to pass the synchronisers
   task automatic drive(input logic [11:0] v, input logic [9:0] d);
      IN_PIN <= v;
      drv <= d;
      repeat (8) @(posedge CLK_SYS);
   endtask
   // one pin clock pulse, prompt or slow; held high through a preset
   task automatic pulse(input int w);
      CLK_PIN <= 1'b1;
      repeat (w) @(posedge CLK_SYS);
      CLK_PIN <= 1'b0;
      repeat (w) @(posedge CLK_SYS);
   endtask
endmodule

// File: tb/test_pld_dual_register_macrocell.sv
// test_pld_dual_register_macrocell: self-checking bench of the array
// assumes: pldm_top, pldm_board and the bound checker
`timescale 1ns/1ps
module test_pld_dual_register_macrocell
   import pldm_pkg::*;
;
   logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, clk_pin, rd_err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_data;
   logic [11:0] in_pin, v;
   logic [9:0] io_in, io_out, io_oe, d;
   logic [19:0] q_exp;
   int miscompares, tests_run, seed;
   // 200 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   pldm_top dut (.CLK_SYS(clk_sys), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .CLK_PIN(clk_pin), .IN_PIN(in_pin), .IO_IN(io_in),
      .IO_OUT(io_out), .IO_OE(io_oe));
   pldm_board board (.CLK_SYS(clk_sys), .IO_OUT(io_out), .IO_OE(io_oe),
      .CLK_PIN(clk_pin), .IN_PIN(in_pin), .IO_IN(io_in));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic f_next(logic t, logic q, logic s);
      return t ? q ^ s : s;
   endfunction
   function automatic logic [31:0] f_sec(logic [7:0] a);
      if (a == PLDM_ADDR_TYPE || a == PLDM_ADDR_CSEL) return 32'h000fffff;
      if (a == PLDM_ADDR_MASK_HI || a == PLDM_ADDR_VAL_HI) return 32'h000003ff;
      return 32'hffffffff;
   endfunction
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         final_report();
      end
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   // term true when one array input is high
   task automatic term(input int idx, input int bit_no);
      logic [41:0] m;
      m = 42'h1 << bit_no;
      apb(1'b1, PLDM_ADDR_TIDX, 32'(idx));
      apb(1'b1, PLDM_ADDR_MASK_LO, m[31:0]);
      apb(1'b1, PLDM_ADDR_MASK_HI, {22'h0, m[41:32]});
      apb(1'b1, PLDM_ADDR_VAL_LO, m[31:0]);
      apb(1'b1, PLDM_ADDR_VAL_HI, {22'h0, m[41:32]});
   endtask
   task automatic do_reset;
      rst_b <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
   endtask
   task automatic state_is;
      apb(1'b0, PLDM_ADDR_STATE, 32'h0);
      check(rd_data, {12'h0, q_exp});
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      seed = 24240;
      miscompares = 0;
      tests_run = 0;
      {rst_b, psel, penable, pwrite, paddr, pwdata} = 44'h0;
      q_exp = PLDM_Q_RST;
      do_reset();
      for (int k = 0; k < 10; k++) begin
         apb(1'b0, 8'(4 * k), 32'h0);
         check(rd_data, 32'h0);
      end
      apb(1'b1, 8'h28, 32'(($random(seed))));
      check({31'h0, rd_err}, 32'h1);
      // refused read: error flag and zero data
      apb(1'b0, 8'h28, 32'h0);
      check(rd_data, 32'h0);
      check({31'h0, rd_err}, 32'h1);
      // T on register 1; pin clock for 0, 1, 15; register 2 on its clock term
      apb(1'b1, PLDM_ADDR_TYPE, 32'h00002);
      apb(1'b1, PLDM_ADDR_CSEL, 32'h08003);
      term(0, 30);
      term(PLDM_PT_PER_SUM, 31);
      term(2 * PLDM_PT_PER_SUM, 36);
      term(15 * PLDM_PT_PER_SUM, 0);
      term(PLDM_T_RST_BASE, 32);
      term(PLDM_T_CLK_BASE + 2, 35);
      term(PLDM_T_OE_BASE, 34);
      term(PLDM_T_PRESET, 33);
      apb(1'b1, PLDM_ADDR_CTRL, 32'h2);
      for (int i = 0; i < 8; i++) begin
         v = 12'($random(seed)) & 12'h053;
         d = 10'($random(seed));
         board.drive(v, d);
         board.drive(v | 12'h020, d);
         board.pulse(4 + i % 3);
         q_exp[15] = q_exp[0];
         q_exp[0] = f_next(1'b0, q_exp[0], v[0]);
         q_exp[1] = f_next(1'b1, q_exp[1], v[1]);
         q_exp[2] = v[6];
         state_is();
         check({22'h0, io_oe}, {31'h0, v[4]});
         check({22'h0, io_out}, {22'h0, q_exp[9:0]});
         apb(1'b0, PLDM_ADDR_PINS, 32'h0);
         check(rd_data, {10'h0, v | 12'h020, d[9:1], v[4] ? q_exp[0] : d[0]});
      end
      // set register 0, then its reset term clears it with no clock
      board.drive(12'h001, 10'h0);
      board.pulse(4);
      q_exp[15] = q_exp[0];
      q_exp[0] = 1'b1;
      board.drive(12'h005, 10'h0);
      q_exp[0] = 1'b0;
      state_is();
      board.pulse(5);
      q_exp[15] = 1'b0;
      state_is();
      // preset on the pin clock edge
      board.drive(12'h008, 10'h0);
      board.pulse(4);
      q_exp = q_exp | 20'h08003;
      state_is();
      // stopped: no change on a clock edge
      apb(1'b1, PLDM_ADDR_CTRL, 32'h0);
      board.drive(12'h000, 10'h0);
      board.pulse(4);
      state_is();
      // security set as the last step
      apb(1'b1, PLDM_ADDR_CTRL, 32'h3);
      for (int k = 1; k < 8; k++) begin
         if (k != 3) begin
            apb(1'b0, 8'(4 * k), 32'h0);
            check(rd_data, f_sec(8'(4 * k)));
         end
      end
      apb(1'b1, PLDM_ADDR_CTRL, 32'h0);
      apb(1'b0, PLDM_ADDR_CTRL, 32'h0);
      check(rd_data & 32'h1, 32'h1);
      do_reset();
      apb(1'b0, PLDM_ADDR_CTRL, 32'h0);
      check(rd_data, 32'h0);
      final_report();
   end
endmodule
